// File: bench/dual_mono_moving_delay_tb_top.sv
// Self-checking testbench for the dual mono moving delay block.
`timescale 1ns/1ps
`default_nettype none
module dual_mono_moving_delay_tb_top;
  import mdl_pkg::*;
  typedef struct packed {
    logic [15:0] wd;
    logic [15:0] gain;
    logic        off;
    stereo_s     din;
    stereo_s     dout;
  } row_s;
  // Dry path rows; the last one drives the output into saturation.
  localparam row_s ROWS [6] = '{
    '{16'h0000, 16'h0800, 1'b0, 32'h1234EDCC, 32'h1234EDCC},
    '{16'h0000, 16'h1000, 1'b0, 32'h1234EDCC, 32'h2468DB98},
    '{16'h0000, 16'h0800, 1'b1, 32'h1234EDCC, 32'h00000000},
    '{16'h0000, 16'h0800, 1'b0, 32'h7FFF8000, 32'h7FFF8000},
    '{16'h8000, 16'h0800, 1'b0, 32'h1234EDCC, 32'h00000000},
    '{16'h0000, 16'h4000, 1'b0, 32'h70009000, 32'h7FFF8000}};
  logic        clock;
  logic        rst_n;
  logic        quad_mode;
  logic        in_valid;
  logic        in_ready;
  logic        out_valid;
  logic        out_ready;
  stereo_s     in_data;
  stereo_s     out_data;
  circ_cfg_s   circ_cfg [NUM_CIRC];
  chan_cfg_s   chan_cfg [2];
  logic [15:0] blend_l;
  logic [15:0] blend_r;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cycles = 0;

  // At 10 kHz one 0.1 ms delay step is exactly one sample.
  moving_delay #(.SAMPLE_RATE_HZ(10000), .DELAY_DEPTH(64)) moving_delay_inst (
    .clock(clock), .rst_n(rst_n), .quad_mode(quad_mode),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
    .circ_cfg(circ_cfg), .chan_cfg(chan_cfg),
    .cascade_blend_left(blend_l), .cascade_blend_right(blend_r));

  sample_host sample_host_inst (
    .clock(clock), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("FAIL run length expected below 20000 seen 20000");
      stop_test();
    end
  end

  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Level check: k=1 clearly positive, k=-1 clearly negative, k=0 near zero.
  task automatic lvl(string what, logic signed [15:0] v, int k);
    logic ok;
    num_checks++;
    ok = (k > 0) ? (v > 16'sh0800) : (k < 0) ? (v < -16'sh0800) :
         (v > -16'sh0040 && v < 16'sh0040);
    if (ok !== 1'b1) begin
      fail_count++;
      $display("FAIL %s expected sign %0d seen %h", what, k, v);
    end
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    tick(20);
    rst_n = 1'b1;
    sample_host_inst.got_q.delete();
  endtask

  task automatic base();
    for (int i = 0; i < NUM_CIRC; i++) begin
      circ_cfg[i] = '{SWEEP_STATIC, 10'h000, 11'h000, 14'h0005, 16'sh0000,
                      15'h6200, 16'sh7FFF, (i < 2) ? 16'sh8000 : 16'sh7FFF};
    end
    chan_cfg[0] = '{16'sh7FFF, 16'h0800, 1'b0, 16'sh8000};
    chan_cfg[1] = '{16'sh0000, 16'h0800, 1'b0, 16'sh7FFF};
    quad_mode = 1'b0;
    blend_l = 16'h0000;
    blend_r = 16'h0000;
  endtask

  // An impulse followed by zeros; waits for all outputs under a bound.
  task automatic run(int n, logic [15:0] l, logic [15:0] r);
    sample_host_inst.got_q.delete();
    sample_host_inst.src_q.push_back({l, r});
    repeat (n - 1) sample_host_inst.src_q.push_back(32'h00000000);
    for (int i = 0; i < 2000 && sample_host_inst.got_q.size() < n; i++) tick(1);
    chk("output count", 16'(n), 16'(sample_host_inst.got_q.size()));
  endtask

  task automatic done(string name);
    $display("test %s done", name);
  endtask

  initial begin
    rst_n = 1'b0;
    base();
    tick(20);
    chk("reset valid", 16'h0000, 16'(out_valid));
    chk("reset data", 16'h0000, out_data.left);
    chk("reset ready", 16'h0001, 16'(in_ready));
    do_reset();
    foreach (ROWS[i]) begin
      base();
      for (int j = 0; j < NUM_CIRC; j++) circ_cfg[j].mix = 16'sh0000;
      for (int j = 0; j < 2; j++) begin
        chan_cfg[j].wet_dry = ROWS[i].wd;
        chan_cfg[j].out_gain = ROWS[i].gain;
        chan_cfg[j].gain_off = ROWS[i].off;
      end
      run(1, ROWS[i].din.left, ROWS[i].din.right);
      chk("row left", ROWS[i].dout.left, sample_host_inst.got_q[0].left);
      chk("row right", ROWS[i].dout.right, sample_host_inst.got_q[0].right);
    end
    done("dry rows");
    for (int m = 0; m < 4; m++) begin
      do_reset();
      base();
      circ_cfg[0].sweep_type = sweep_type_e'(m);
      circ_cfg[0].sweep_speed = 10'h3E8;
      circ_cfg[0].sweep_depth = (m == 3) ? 11'h7D0 : 11'h000;
      run(12, 16'h4000, 16'h2000);
      chk("right dry", 16'h2000, sample_host_inst.got_q[0].right);
      lvl("left tap", sample_host_inst.got_q[5].left, 1);
      lvl("left early", sample_host_inst.got_q[4].left, 0);
      lvl("left late", sample_host_inst.got_q[6].left, 0);
      lvl("right tap", sample_host_inst.got_q[5].right, 0);
    end
    // Full depth pulls the tap off its center on the very next sample.
    for (int k = 0; k < 2; k++) begin
      do_reset();
      base();
      circ_cfg[0].sweep_type = k ? SWEEP_TRI : SWEEP_FLANGE;
      circ_cfg[0].sweep_speed = 10'h3E8;
      circ_cfg[0].sweep_depth = 11'h7D0;
      run(12, 16'h4000, 16'h0000);
      lvl("swept", sample_host_inst.got_q[1 + 3 * k].left, 1);
      lvl("unswept", sample_host_inst.got_q[5].left, 0);
    end
    done("sweep types");
    for (int k = 0; k < 3; k++) begin
      base();
      circ_cfg[0].mix = (k == 1) ? 16'sh7FFF : 16'sh8000;
      chan_cfg[0].wet_dry = (k == 0) ? 16'sh7FFF : 16'sh8000;
      run(12, 16'h4000, 16'h0000);
      lvl("polarity", sample_host_inst.got_q[5].left, (k == 2) ? 1 : -1);
    end
    done("polarity");
    for (int k = 0; k < 2; k++) begin
      do_reset();
      base();
      circ_cfg[0].feedback = k ? 16'shC000 : 16'sh4000;
      run(12, 16'h4000, 16'h0000);
      lvl("echo", sample_host_inst.got_q[10].left, k ? -1 : 1);
    end
    do_reset();
    base();
    // A long tap reads words that only stale memory could still hold.
    circ_cfg[0].center_delay = 14'h003A;
    run(12, 16'h4000, 16'h0000);
    lvl("cleared echo", sample_host_inst.got_q[4].left, 0);
    done("feedback");
    for (int k = 0; k < 2; k++) begin
      base();
      circ_cfg[0].pan = k ? 16'sh7FFF : 16'sh0000;
      run(12, 16'h4000, 16'h0000);
      lvl("pan left", sample_host_inst.got_q[5].left, k ? 0 : 1);
      lvl("pan right", sample_host_inst.got_q[5].right, 1);
    end
    done("pan");
    for (int k = 0; k < 2; k++) begin
      do_reset();
      base();
      quad_mode = 1'b1;
      circ_cfg[0].mix = 16'sh0000;
      circ_cfg[1].center_delay = 14'h0003;
      blend_l = k ? 16'h8000 : 16'h0000;
      run(12, 16'h4000, 16'h0000);
      lvl("cascade dry", sample_host_inst.got_q[3].left, k ? 0 : 1);
      lvl("cascade first", sample_host_inst.got_q[8].left, k ? 1 : 0);
    end
    base();
    quad_mode = 1'b1;
    chan_cfg[0].wet_dry = 16'sh0000;
    chan_cfg[0].dry_pan = 16'sh7FFF;
    run(4, 16'h4000, 16'h0000);
    lvl("dry pan right", sample_host_inst.got_q[0].right, 1);
    lvl("dry pan left", sample_host_inst.got_q[0].left, 0);
    done("four line");
    do_reset();
    base();
    chan_cfg[0].wet_dry = 16'sh0000;
    sample_host_inst.hold = 1'b1;
    for (int i = 0; i < 20; i++) sample_host_inst.src_q.push_back({16'(i * 256 + 1), 16'(-i)});
    tick(300);
    chk("fifo left over", 16'h0003, 16'(sample_host_inst.src_q.size()));
    chk("full ready", 16'h0000, 16'(in_ready));
    sample_host_inst.hold = 1'b0;
    sample_host_inst.slow = 1'b1;
    for (int i = 0; i < 2000 && sample_host_inst.got_q.size() < 20; i++) tick(1);
    for (int i = 0; i < 20; i++) begin
      chk("drain left", 16'(i * 256 + 1), sample_host_inst.got_q[i].left);
      chk("drain right", 16'(-i), sample_host_inst.got_q[i].right);
    end
    sample_host_inst.slow = 1'b0;
    done("buffer");
    stop_test();
  end
endmodule
`default_nettype wire

// File: bench/sample_host.sv
// Host side partner: sample source feeding the block and output sink.
`timescale 1ns/1ps
`default_nettype none
module sample_host (
  input  wire logic             clock,
  output logic                  in_valid,
  output mdl_pkg::stereo_s      in_data,
  input  wire logic             in_ready,
  input  wire logic             out_valid,
  input  wire mdl_pkg::stereo_s out_data,
  output logic                  out_ready
);
  import mdl_pkg::*;
  stereo_s src_q [$];
  stereo_s got_q [$];
  logic    hold  = 1'b0;
  logic    slow  = 1'b0;
  logic    phase = 1'b0;

  initial begin
    in_valid = 1'b0;
    in_data = '0;
    out_ready = 1'b1;
  end

  // A word stays on the wires until it is taken; after that the data lines
  // show the next word, or the inverse of the last one once none is left, so that a stale word can never pass for a fresh one.
  always @(posedge clock) begin
    if (out_valid && out_ready) begin
      got_q.push_back(out_data);
    end
    if (in_valid && in_ready) begin
      void'(src_q.pop_front());
    end
    #1;
    phase = ~phase;
    out_ready = !hold && !(slow && phase);
    if (src_q.size() > 0) begin
      in_valid = 1'b1;
      in_data = src_q[0];
    end else begin
      if (in_valid) begin
        in_data = stereo_s'(~in_data);
      end
      in_valid = 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: rtl/mdl_pkg.sv
// Types and constants shared by the dual mono moving delay design.
package mdl_pkg;
  localparam int NUM_CIRC = 4;
  localparam int FIFO_WORDS = 16;
  localparam int SAMPLE_W = 16;
  // Depth code 2000 is 200.0 %; 2^26 / 2000 turns it into a binary fraction.
  localparam int DEPTH_RECIP = 33554;
  localparam int CHORUS_SHIFT = 15;
  localparam logic [15:0] GAIN_UNITY = 16'h0800;
  localparam logic signed [16:0] Q15_ONE = 17'sh08000;
  localparam logic signed [15:0] PAN_HARD_LEFT = 16'sh8000;
  localparam logic signed [15:0] PAN_HARD_RIGHT = 16'sh7FFF;

  typedef enum logic [1:0] {
    SWEEP_FLANGE,
    SWEEP_TRI,
    SWEEP_TRAP,
    SWEEP_STATIC
  } sweep_type_e;

  typedef struct packed {
    sweep_type_e        sweep_type;
    logic [9:0]         sweep_speed;
    logic [10:0]        sweep_depth;
    logic [13:0]        center_delay;
    logic signed [15:0] feedback;
    logic [14:0]        treble_rolloff_cutoff;
    logic signed [15:0] mix;
    logic signed [15:0] pan;
  } circ_cfg_s;

  typedef struct packed {
    logic signed [15:0] wet_dry;
    logic [15:0]        out_gain;
    logic               gain_off;
    logic signed [15:0] dry_pan;
  } chan_cfg_s;

  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } stereo_s;
endpackage

// File: rtl/moving_delay.sv
// Dual mono moving delay lines with optional cascaded second circuits.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Two-line variant: one independent circuit per channel.
// - Four-line: second circuit fed from first plus dry.
// - Blend 0% dry only, 100% first only.
// - Wet/dry 0% dry, 100% wet, negative inverts.
// - Wet/dry acts on summed circuits, pan-independent.
// - Output gain per channel, off or scaled.
// - Signed per-circuit mix levels sum to wet.
// - Signed circuit pan: zero center, sign picks side.
// - Four-line: dry input has own pan.
// - Delay setting up to one second is center.
// - Flange depth sets sweep width around center.
// - Chorus depth fixes pitch deviation, rate-independent.
// - Static mode stops oscillator, ignores rate, depth.
// - Depth spans zero to 200 percent.
// - Per-circuit speed zero to ten hertz.
// - Signed feedback of own output to input.
// - One-pole lowpass damping, 16 to 25088 Hz.
module moving_delay
  import mdl_pkg::*;
#(
  parameter int SAMPLE_RATE_HZ = 48000,
  parameter int DELAY_DEPTH = 48000
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                quad_mode,
  input  wire logic                in_valid,
  input  wire mdl_pkg::stereo_s    in_data,
  output logic                     in_ready,
  output logic                     out_valid,
  output mdl_pkg::stereo_s         out_data,
  input  wire logic                out_ready,
  input  wire mdl_pkg::circ_cfg_s  circ_cfg [mdl_pkg::NUM_CIRC],
  input  wire mdl_pkg::chan_cfg_s  chan_cfg [2],
  input  wire logic [15:0]         cascade_blend_left,
  input  wire logic [15:0]         cascade_blend_right
);
  import mdl_pkg::*;

  localparam int AW = $clog2(DELAY_DEPTH);
  localparam int MW = $clog2(NUM_CIRC * DELAY_DEPTH);
  // Taps per 0.1 ms in Q16: rate * 65536 / 10000.
  localparam int TAP_Q16 = SAMPLE_RATE_HZ * 4096 / 625;
  // Phase step per 0.01 Hz in Q8 of a 24-bit accumulator.
  localparam int PHASE_K = 42949673 / SAMPLE_RATE_HZ;
  // Damping coefficient per Hz in Q8 of Q15: 2*pi*32768*256 / rate.
  localparam int DAMP_K = 52707178 / SAMPLE_RATE_HZ;
  localparam logic [MW-1:0] MEM_LAST = MW'(NUM_CIRC * DELAY_DEPTH - 1);

  typedef enum logic [2:0] {ST_CLEAR, ST_IDLE, ST_CIRC, ST_MIX, ST_OUT}
    state_e;

  function automatic logic signed [15:0] sat16(input logic signed [34:0] v);
    if (v > 35'sh7FFF) return 16'sh7FFF;
    else if (v < -35'sh8000) return 16'sh8000;
    else return v[15:0];
  endfunction

  function automatic logic signed [15:0] mulq(input logic signed [17:0] a,
                                              input logic signed [16:0] b);
    logic signed [34:0] p;
    p = a * b;
    return sat16(p >>> 15);
  endfunction

  // Pan weight 0..32768 per side; a hard pan either way is exact unity.
  function automatic logic signed [16:0] panw(input logic signed [15:0] p,
                                              input logic right);
    logic signed [17:0] s;
    s = right ? 18'(Q15_ONE) + 18'(p) : 18'(Q15_ONE) - 18'(p);
    return (s == 18'sh0FFFF) ? 17'sh08000 : s[17:1];
  endfunction

  function automatic logic signed [17:0] gmul(input logic signed [17:0] v,
                                              input chan_cfg_s cfg);
    logic signed [34:0] p;
    p = v * $signed({1'b0, cfg.out_gain});
    return cfg.gain_off ? 18'sh0 : 18'(sat16(p >>> 11));
  endfunction

  state_e                 state_ff;
  logic [1:0]             idx_ff;
  logic [MW-1:0]          clr_ff;
  logic [AW-1:0]          wr_ptr_ff;
  stereo_s                dry_ff;
  stereo_s                out_ff;
  logic                   out_valid_ff;
  logic signed [15:0]     y_ff [NUM_CIRC];
  logic [23:0]            ph_ff [NUM_CIRC];
  logic signed [31:0]     ofs_ff [NUM_CIRC];
  logic signed [15:0]     mem [NUM_CIRC * DELAY_DEPTH];

  logic                   fifo_valid;
  stereo_s                fifo_data;
  wire                    take = state_ff == ST_IDLE && fifo_valid;

  sample_fifo #(.WIDTH($bits(stereo_s)), .DEPTH(FIFO_WORDS)) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (in_valid),
    .in_data   (in_data),
    .in_ready  (in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (state_ff == ST_IDLE)
  );

  // Selected circuit and the channel it belongs to.
  circ_cfg_s              cc;
  wire                    ch = idx_ff[1];
  wire                    second = idx_ff[0];
  wire logic signed [15:0] dry_c = ch ? dry_ff.right : dry_ff.left;
  wire logic [15:0]       blend = ch ? cascade_blend_right : cascade_blend_left;
  wire logic signed [15:0] first_y = y_ff[{ch, 1'b0}];
  wire                    last = idx_ff == 2'd3 || (!quad_mode && idx_ff == 2'd2);
  assign cc = circ_cfg[idx_ff];

  // Cascade input for the second circuit of a channel.
  wire logic signed [16:0] blend_s = $signed({1'b0, blend});
  wire logic signed [15:0] cin = second ?
    sat16(35'(mulq(18'(first_y), blend_s))
        + 35'(mulq(18'(dry_c), Q15_ONE - blend_s))) : dry_c;

  // Tap position: center from the delay setting plus the moving offset.
  wire logic [32:0] ctr_prod = 33'(cc.center_delay) * 33'(TAP_Q16);
  wire logic [16:0] ctr = ctr_prod[32:16];
  wire logic signed [31:0] tap_s =
    $signed({15'h0, ctr}) + (ofs_ff[idx_ff] >>> 15);
  wire logic [AW-1:0] tap = (tap_s < 32'sh1) ? AW'(1) :
    (tap_s > 32'(DELAY_DEPTH - 1)) ? AW'(DELAY_DEPTH - 1) : tap_s[AW-1:0];
  wire logic [AW-1:0] rd_ofs = (wr_ptr_ff >= tap) ? wr_ptr_ff - tap :
    AW'(wr_ptr_ff + AW'(DELAY_DEPTH) - tap);
  wire logic [MW-1:0] base = MW'(idx_ff) * MW'(DELAY_DEPTH);
  wire logic signed [15:0] tap_val = mem[base + MW'(rd_ofs)];

  // Oscillator: triangle from phase, trapezoid by clipping twice of it.
  wire logic [23:0] ph = ph_ff[idx_ff];
  wire logic [23:0] ph_inc =
    24'((32'(cc.sweep_speed) * 32'(PHASE_K)) >> 8);
  wire logic [15:0] ramp = ph[23] ? ~ph[22:7] : ph[22:7];
  wire logic signed [15:0] tri_w = $signed(ramp ^ 16'h8000);
  wire logic signed [15:0] trap_w = sat16(35'(tri_w) <<< 1);
  wire logic [43:0] exc_prod =
    44'(ctr) * 44'(cc.sweep_depth) * 44'(DEPTH_RECIP);
  wire logic [16:0] exc = exc_prod[42:26];
  wire logic signed [31:0] ofs_flange = $signed({1'b0, exc}) * tri_w;
  wire logic signed [15:0] shape = cc.sweep_type == SWEEP_TRAP ? trap_w : tri_w;
  // Chorus moves the tap at a slope set by depth alone, so the pitch
  // deviation stays fixed while a slower rate simply sweeps farther.
  wire logic signed [31:0] slope =
    32'(($signed({1'b0, cc.sweep_depth}) * shape) >>> CHORUS_SHIFT);
  logic signed [31:0] nxt_ofs;
  logic [23:0]        nxt_ph;
  always_comb begin
    nxt_ph = ph + ph_inc;
    unique case (cc.sweep_type)
      SWEEP_FLANGE: nxt_ofs = ofs_flange;
      SWEEP_TRI, SWEEP_TRAP: nxt_ofs = ofs_ff[idx_ff] + slope;
      SWEEP_STATIC: begin
        nxt_ofs = '0;
        nxt_ph = ph;
      end
    endcase
  end

  // Damping filter and feedback into the delay input.
  wire logic [31:0] damp_p = (32'(cc.treble_rolloff_cutoff) * 32'(DAMP_K)) >> 8;
  wire logic [15:0] damp_a = (damp_p > 32'h7FFF) ? 16'h7FFF : damp_p[15:0];
  wire logic signed [16:0] diff = 17'(tap_val) - 17'(y_ff[idx_ff]);
  wire logic signed [15:0] y_new = sat16(35'(y_ff[idx_ff])
    + 35'(mulq(18'(diff), $signed({1'b0, damp_a}))));
  wire logic signed [15:0] wr_val = sat16(35'(cin)
    + 35'(mulq(18'(y_new), 17'(cc.feedback))));

  wire clearing = state_ff == ST_CLEAR;
  wire logic [MW-1:0] mem_wa = clearing ? clr_ff : base + MW'(wr_ptr_ff);

  always_ff @(posedge clock) begin
    if (clearing || state_ff == ST_CIRC) begin
      mem[mem_wa] <= clearing ? 16'sh0 : wr_val;
    end
  end

  // Output mix: circuits are mixed and panned per channel, then the
  // channel's wet sum is balanced against its own dry input.
  logic signed [17:0] mix_l;
  logic signed [17:0] mix_r;
  always_comb begin
    logic signed [17:0] wl;
    logic signed [17:0] wr;
    logic signed [15:0] v;
    logic signed [15:0] dr;
    logic signed [15:0] dp;
    logic signed [16:0] wd;
    logic signed [16:0] dlev;
    wl = '0;
    wr = '0;
    v = '0;
    dr = '0;
    dp = '0;
    wd = '0;
    dlev = '0;
    mix_l = '0;
    mix_r = '0;
    for (int c = 0; c < 2; c++) begin
      wl = '0;
      wr = '0;
      for (int k = 0; k < 2; k++) begin
        if (k == 0 || quad_mode) begin
          v = mulq(18'(y_ff[2*c+k]), 17'(circ_cfg[2*c+k].mix));
          wl = wl + 18'(mulq(18'(v), panw(circ_cfg[2*c+k].pan, 1'b0)));
          wr = wr + 18'(mulq(18'(v), panw(circ_cfg[2*c+k].pan, 1'b1)));
        end
      end
      wd = 17'(chan_cfg[c].wet_dry);
      dlev = Q15_ONE - (wd < 0 ? -wd : wd);
      dr = mulq(18'(c == 1 ? dry_ff.right : dry_ff.left), dlev);
      dp = quad_mode ? chan_cfg[c].dry_pan :
           (c == 1 ? PAN_HARD_RIGHT : PAN_HARD_LEFT);
      mix_l = mix_l + gmul(18'(mulq(wl, wd))
        + 18'(mulq(18'(dr), panw(dp, 1'b0))), chan_cfg[c]);
      mix_r = mix_r + gmul(18'(mulq(wr, wd))
        + 18'(mulq(18'(dr), panw(dp, 1'b1))), chan_cfg[c]);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= ST_CLEAR;
      idx_ff <= '0;
      clr_ff <= '0;
    end else begin
      unique case (state_ff)
        ST_CLEAR: begin
          clr_ff <= clr_ff + MW'(1);
          if (clr_ff == MEM_LAST) state_ff <= ST_IDLE;
        end
        ST_IDLE: if (fifo_valid) state_ff <= ST_CIRC;
        ST_CIRC: begin
          idx_ff <= last ? 2'd0 : idx_ff + (quad_mode ? 2'd1 : 2'd2);
          if (last) state_ff <= ST_MIX;
        end
        ST_MIX: state_ff <= ST_OUT;
        ST_OUT: if (out_ready) state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int k = 0; k < NUM_CIRC; k++) begin
        y_ff[k] <= '0;
        ph_ff[k] <= '0;
        ofs_ff[k] <= '0;
      end
    end else if (state_ff == ST_CIRC) begin
      y_ff[idx_ff] <= y_new;
      ph_ff[idx_ff] <= nxt_ph;
      ofs_ff[idx_ff] <= nxt_ofs;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dry_ff <= '0;
      out_ff <= '0;
      out_valid_ff <= 1'b0;
      wr_ptr_ff <= '0;
    end else begin
      if (take) dry_ff <= fifo_data;
      if (state_ff == ST_MIX) begin
        out_ff.left <= sat16(35'(mix_l));
        out_ff.right <= sat16(35'(mix_r));
        out_valid_ff <= 1'b1;
        wr_ptr_ff <= (wr_ptr_ff == AW'(DELAY_DEPTH - 1)) ? '0 :
                     wr_ptr_ff + AW'(1);
      end else if (out_ready) begin
        out_valid_ff <= 1'b0;
      end
    end
  end

  assign out_valid = out_valid_ff;
  assign out_data = out_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_take_dual;
    state_ff == ST_IDLE && fifo_valid && !quad_mode;
  endsequence
  sequence s_run_dual;
    (state_ff == ST_CIRC) [*2] ##1 state_ff == ST_MIX;
  endsequence

  chk_dual_run_len: assert property (s_take_dual |=> s_run_dual)
    else $error("Two-line sample did not take two circuit steps.");
  chk_dual_skip_odd: assert property (
    state_ff == ST_CIRC && !quad_mode |-> !idx_ff[0])
    else $error("Second circuit ran in two-line variant.");
  chk_cascade_order: assert property (
    state_ff == ST_CIRC && idx_ff[0] |-> $past(idx_ff) == {idx_ff[1], 1'b0})
    else $error("Second circuit ran before its first circuit.");
  chk_blend_dry_only: assert property (
    state_ff == ST_CIRC && idx_ff[0] && blend == 16'h0000 |-> cin == dry_c)
    else $error("Zero blend did not pass only the dry input.");
  chk_static_stop: assert property (
    state_ff == ST_CIRC && cc.sweep_type == SWEEP_STATIC
    |=> ofs_ff[$past(idx_ff)] == 0 && ph_ff[$past(idx_ff)] == $past(ph))
    else $error("Static mode moved the tap or the phase.");
  chk_dry_passes: assert property (
    state_ff == ST_MIX && !quad_mode && chan_cfg[0].wet_dry == 0
    && chan_cfg[1].wet_dry == 0 && chan_cfg[0].out_gain == GAIN_UNITY
    && chan_cfg[1].out_gain == GAIN_UNITY && !chan_cfg[0].gain_off
    && !chan_cfg[1].gain_off |=> out_data == $past(dry_ff))
    else $error("Fully dry setting did not pass the input.");
  chk_gain_off_mute: assert property (
    state_ff == ST_MIX && chan_cfg[0].gain_off && chan_cfg[1].gain_off
    |=> out_data == '0)
    else $error("Gain off did not silence the output.");
  chk_tap_in_range: assert property (
    state_ff == ST_CIRC |-> tap >= AW'(1) && tap <= AW'(DELAY_DEPTH - 1))
    else $error("Delay tap left the delay memory.");
  chk_out_holds: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("Output sample changed while stalled.");
  chk_clear_done: assert property (
    state_ff == ST_CLEAR && clr_ff == MEM_LAST |=> state_ff == ST_IDLE)
    else $error("Memory clear did not end after the last word.");
endmodule
`default_nettype wire

// File: rtl/sample_fifo.sv
// Parameterised valid/ready FIFO for incoming stereo samples.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  wire              push = in_valid && in_ready;
  wire              pop = out_valid && out_ready;

  assign in_ready = (wr_ff - rd_ff) != (AW + 1)'(DEPTH);
  assign out_valid = wr_ff != rd_ff;
  assign out_data = store[rd_ff[AW-1:0]];

  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= wr_ff + (AW + 1)'(push);
      rd_ff <= rd_ff + (AW + 1)'(pop);
    end
  end
endmodule
`default_nettype wire
